// [design/rls_bank.sv]
// Behaviour
// - count every sent byte, headers included
// - byte tally is 16 bits, wraps
// - host may load any 16-bit counter value
// - keep 8-bit last-hop signal magnitude
// - signal level reads zero until first packet
// - level and tallies volatile, reset on power-up
// - bad-packet tally counts errors, saturates
// - good-packet tally skips acks, saturates
// - ack-timeout tally counts timeouts, saturates
// - send-failure tally counts exhausted retries, saturates
// - acked-unicast tally counts ack requests, saturates
// - unicast hop timeout read-only, default 0xCF
// - broadcast hop timeout read-only, default 0x1BE
// - role bits: hold, no-route, poll
// - hold and poll never together, 0..6
// - flood hops 0..0x20, clipped to max hops
// - max hops 1..0x20, default 7
// - relay wait random slots up to span
// - resend cap 0..7 enables network acks
// - resend backoff random 38 ms slots
// - factory address read-only in two halves
// - target address writable, resets 0/0xFFFF
`timescale 1ns/1ps
`default_nettype none

module rls_bank
  import rls_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES   // cycles per 38 ms slot
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // host command port
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [4:0]  cmd_idx,
  input  wire logic [31:0] cmd_wdata,
  output logic [31:0]      cmd_rdata,
  output logic             cmd_ack,
  output logic             cmd_err,
  // radio events, one-cycle pulses from the same clock
  input  wire logic        ev_tx_byte,
  input  wire logic        ev_rx_bad,
  input  wire logic        ev_rx_good,
  input  wire logic        ev_rx_is_ack,
  input  wire logic        ev_ack_timeout,
  input  wire logic        ev_send_fail,
  input  wire logic        ev_acked_unicast,
  input  wire logic        ev_rx_data,
  input  wire logic [7:0]  rx_level_in,
  // timeouts computed by the mac engine
  input  wire logic        hop_tmo_load,
  input  wire logic [15:0] uni_hop_tmo_in,
  input  wire logic [15:0] bc_hop_tmo_in,
  // backoff requests
  input  wire logic        relay_wait_req,
  input  wire logic        resend_wait_req,
  output logic             relay_wait_busy,
  output logic             resend_wait_busy,
  // configuration seen by the network layer
  output logic [7:0]       role_bits,
  output logic [7:0]       flood_hops_eff,
  output logic [7:0]       max_hops,
  output logic             net_ack_en,
  output logic [3:0]       net_send_tries,
  output logic [63:0]      target_address
);

  // counters and parameters
  logic [15:0] tx_byte_tally_r;
  logic [15:0] bad_packet_tally_r;
  logic [15:0] good_packet_tally_r;
  logic [15:0] ack_timeout_tally_r;
  logic [15:0] send_fail_tally_r;
  logic [15:0] acked_unicast_tally_r;
  logic [7:0]  last_rx_signal_level_r;
  logic [15:0] unicast_hop_timeout_r;
  logic [15:0] broadcast_hop_timeout_r;
  logic [7:0]  messaging_role_bits_r;
  logic [7:0]  flood_hop_limit_r;
  logic [7:0]  max_hop_count_r;
  logic [7:0]  relay_backoff_span_r;
  logic [7:0]  path_resend_cap_r;
  logic [7:0]  resend_backoff_max_r;
  logic [31:0] target_address_top_r;
  logic [31:0] target_address_bottom_r;
  logic [15:0] lfsr_r;            // random source for slot picks

  // write strobe per index
  function automatic logic wr_hit(input logic [4:0] idx);
    wr_hit = cmd_wr && (cmd_idx == idx);
  endfunction

  // saturating step; a host load beats the event in the same cycle
  function automatic logic [15:0] sat_step(input logic [15:0] v, input logic ev);
    sat_step = (ev && v != TALLY_MAX) ? v + 16'h0001 : v;
  endfunction

  // value check for writable parameters; bad values rejected whole
  // only the 8-bit parameters need bits 31:8 clear; tallies are checked
  // on bits 31:16 further down, and the target halves take any word
  function automatic logic cfg_ok(input logic [4:0] idx, input logic [7:0] v, input logic [23:0] hi);
    logic hi_clr;                 // upper bits of the write word all zero
    hi_clr = (hi == 24'h00_0000);
    unique case (idx)
      REG_ROLE:        cfg_ok = hi_clr && (v <= ROLE_MAX) && !(v[ROLE_HOLD_BIT] && v[ROLE_POLL_BIT]);
      REG_FLOOD_HOPS:  cfg_ok = hi_clr && (v <= HOPS_LIMIT);
      REG_MAX_HOPS:    cfg_ok = hi_clr && (v >= HOPS_MIN) && (v <= HOPS_LIMIT);
      REG_RELAY_SPAN:  cfg_ok = hi_clr && (v >= RELAY_SPAN_MIN) && (v <= RELAY_SPAN_MAX);
      REG_RESEND_CAP:  cfg_ok = hi_clr && (v <= RESEND_CAP_MAX);
      REG_BACKOFF_MAX: cfg_ok = hi_clr;
      default:         cfg_ok = 1'b1;
    endcase
  endfunction

  logic cfg_good;
  assign cfg_good = cfg_ok(cmd_idx, cmd_wdata[7:0], cmd_wdata[31:8]);

  // byte tally wraps rather than saturating
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tx_byte_tally_r <= TALLY_RST;
    else if (wr_hit(REG_TX_BYTE))
      tx_byte_tally_r <= cmd_wdata[15:0];
    else if (ev_tx_byte)
      tx_byte_tally_r <= tx_byte_tally_r + 16'h0001;
  end

  // saturating event tallies
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bad_packet_tally_r    <= TALLY_RST;
      good_packet_tally_r   <= TALLY_RST;
      ack_timeout_tally_r   <= TALLY_RST;
      send_fail_tally_r     <= TALLY_RST;
      acked_unicast_tally_r <= TALLY_RST;
    end
    else
    begin
      // each load wins over an event in the same cycle
      if (wr_hit(REG_BAD_PKT)) bad_packet_tally_r <= cmd_wdata[15:0];
      else bad_packet_tally_r <= sat_step(bad_packet_tally_r, ev_rx_bad);
      if (wr_hit(REG_GOOD_PKT)) good_packet_tally_r <= cmd_wdata[15:0];
      else good_packet_tally_r <= sat_step(good_packet_tally_r, ev_rx_good && !ev_rx_is_ack);
      if (wr_hit(REG_ACK_TMO)) ack_timeout_tally_r <= cmd_wdata[15:0];
      else ack_timeout_tally_r <= sat_step(ack_timeout_tally_r, ev_ack_timeout);
      if (wr_hit(REG_SEND_FAIL)) send_fail_tally_r <= cmd_wdata[15:0];
      else send_fail_tally_r <= sat_step(send_fail_tally_r, ev_send_fail);
      if (wr_hit(REG_ACKED_UNI)) acked_unicast_tally_r <= cmd_wdata[15:0];
      else acked_unicast_tally_r <= sat_step(acked_unicast_tally_r, ev_acked_unicast);
    end
  end

  // last-hop signal level, zero until the first data packet
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      last_rx_signal_level_r <= RX_LEVEL_RST;
    else if (ev_rx_data)
      last_rx_signal_level_r <= rx_level_in;
  end

  // hop timeouts: host cannot write, mac engine refreshes them
  // no host path here: writes to these indices answer with an error
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unicast_hop_timeout_r   <= UNI_HOP_TMO_RST;
      broadcast_hop_timeout_r <= BC_HOP_TMO_RST;
    end
    else if (hop_tmo_load)
    begin
      unicast_hop_timeout_r   <= uni_hop_tmo_in;
      broadcast_hop_timeout_r <= bc_hop_tmo_in;
    end
  end

  // network parameters, out-of-range writes leave old value
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      messaging_role_bits_r   <= ROLE_RST;
      flood_hop_limit_r       <= FLOOD_HOPS_RST;
      max_hop_count_r         <= MAX_HOPS_RST;
      relay_backoff_span_r    <= RELAY_SPAN_RST;
      path_resend_cap_r       <= RESEND_CAP_RST;
      resend_backoff_max_r    <= BACKOFF_MAX_RST;
      target_address_top_r    <= TGT_TOP_RST;
      target_address_bottom_r <= TGT_BOT_RST;
    end
    else if (cmd_wr && cfg_good)
    begin
      unique case (cmd_idx)
        REG_ROLE:        messaging_role_bits_r <= cmd_wdata[7:0];
        REG_FLOOD_HOPS:  flood_hop_limit_r <= cmd_wdata[7:0];
        REG_MAX_HOPS:    max_hop_count_r <= cmd_wdata[7:0];
        REG_RELAY_SPAN:  relay_backoff_span_r <= cmd_wdata[7:0];
        REG_RESEND_CAP:  path_resend_cap_r <= cmd_wdata[7:0];
        REG_BACKOFF_MAX: resend_backoff_max_r <= cmd_wdata[7:0];
        REG_TGT_TOP:     target_address_top_r <= cmd_wdata;
        REG_TGT_BOT:     target_address_bottom_r <= cmd_wdata;
        default:         ;
      endcase
    end
  end

  // free-running lfsr for random slot counts
  // both waits share one lfsr, so their picks correlate; fine for a backoff
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      lfsr_r <= LFSR_SEED;
    else
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
  end

  // slot tick shared by both waits
  // free-running, so a wait starts mid-slot and its first slot is short
  logic [31:0] slot_cnt_r;
  logic        slot_tick;
  assign slot_tick = (slot_cnt_r == 32'(SLOT_LEN - 1));
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      slot_cnt_r <= 32'h0000_0000;
    else if (slot_tick)
      slot_cnt_r <= 32'h0000_0000;
    else
      slot_cnt_r <= slot_cnt_r + 32'h0000_0001;
  end

  // relay wait: random 0..span slots; slot length reused, limitation
  // a pick of zero still holds busy until the next slot tick, so the
  // wait always ends on a tick edge
  logic [7:0] relay_left_r;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      relay_left_r    <= 8'h00;
      relay_wait_busy <= 1'b0;
    end
    else if (relay_wait_req && !relay_wait_busy)
    begin
      relay_left_r    <= 8'(lfsr_r[7:0] % (relay_backoff_span_r + 8'h01));
      relay_wait_busy <= 1'b1;
    end
    else if (relay_wait_busy && slot_tick)
    begin
      if (relay_left_r == 8'h00)
        relay_wait_busy <= 1'b0;
      else
        relay_left_r <= relay_left_r - 8'h01;
    end
  end

  // resend wait: random 0..max-1 slots of 38 ms, none when max is zero
  // a pick of n clears busy on the n-th tick, the first one possibly partial
  logic [7:0] resend_left_r;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resend_left_r    <= 8'h00;
      resend_wait_busy <= 1'b0;
    end
    else if (resend_wait_req && !resend_wait_busy)
    begin
      if (resend_backoff_max_r != 8'h00)
      begin
        resend_left_r    <= 8'(lfsr_r[15:8] % resend_backoff_max_r);
        resend_wait_busy <= (lfsr_r[15:8] % resend_backoff_max_r) != 8'h00;
      end
    end
    else if (resend_wait_busy && slot_tick)
    begin
      if (resend_left_r <= 8'h01)
        resend_wait_busy <= 1'b0;
      else
        resend_left_r <= resend_left_r - 8'h01;
    end
  end

  // configuration outputs, registered
  // one cycle behind the registers, so the network layer sees clean values
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      role_bits      <= ROLE_RST;
      flood_hops_eff <= FLOOD_HOPS_RST;
      max_hops       <= MAX_HOPS_RST;
      net_ack_en     <= NET_ACK_EN_RST;
      net_send_tries <= NET_TRIES_RST;
      target_address <= {TGT_TOP_RST, TGT_BOT_RST};
    end
    else
    begin
      role_bits      <= messaging_role_bits_r;
      flood_hops_eff <= (flood_hop_limit_r > max_hop_count_r) ? max_hop_count_r : flood_hop_limit_r;
      max_hops       <= max_hop_count_r;
      net_ack_en     <= path_resend_cap_r != 8'h00;
      net_send_tries <= (path_resend_cap_r != 8'h00) ? 4'(path_resend_cap_r + 8'h01) : 4'h1;
      target_address <= {target_address_top_r, target_address_bottom_r};
    end
  end

  // read mux
  // unknown indices fall to the default and raise the error answer
  logic [31:0] rd_val;
  logic        rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    unique case (cmd_idx)
      REG_TX_BYTE:     rd_val = {16'h0000, tx_byte_tally_r};
      REG_RX_LEVEL:    rd_val = {24'h00_0000, last_rx_signal_level_r};
      REG_BAD_PKT:     rd_val = {16'h0000, bad_packet_tally_r};
      REG_GOOD_PKT:    rd_val = {16'h0000, good_packet_tally_r};
      REG_ACK_TMO:     rd_val = {16'h0000, ack_timeout_tally_r};
      REG_SEND_FAIL:   rd_val = {16'h0000, send_fail_tally_r};
      REG_ACKED_UNI:   rd_val = {16'h0000, acked_unicast_tally_r};
      REG_UNI_HOP_TMO: rd_val = {16'h0000, unicast_hop_timeout_r};
      REG_BC_HOP_TMO:  rd_val = {16'h0000, broadcast_hop_timeout_r};
      REG_ROLE:        rd_val = {24'h00_0000, messaging_role_bits_r};
      REG_FLOOD_HOPS:  rd_val = {24'h00_0000, flood_hop_limit_r};
      REG_MAX_HOPS:    rd_val = {24'h00_0000, max_hop_count_r};
      REG_RELAY_SPAN:  rd_val = {24'h00_0000, relay_backoff_span_r};
      REG_RESEND_CAP:  rd_val = {24'h00_0000, path_resend_cap_r};
      REG_BACKOFF_MAX: rd_val = {24'h00_0000, resend_backoff_max_r};
      REG_OWN_TOP:     rd_val = OWN_ADDR_DEF[63:32];
      REG_OWN_BOT:     rd_val = OWN_ADDR_DEF[31:0];
      REG_TGT_TOP:     rd_val = target_address_top_r;
      REG_TGT_BOT:     rd_val = target_address_bottom_r;
      default:         rd_hit = 1'b0;
    endcase
  end

  // write to read-only, unknown index or bad value: error answer
  logic wr_bad;
  assign wr_bad = !rd_hit || !cfg_good || (cmd_idx == REG_RX_LEVEL) || (cmd_idx == REG_UNI_HOP_TMO)
                  || (cmd_idx == REG_BC_HOP_TMO) || (cmd_idx == REG_OWN_TOP) || (cmd_idx == REG_OWN_BOT)
                  || ((cmd_idx <= REG_ACKED_UNI) && (cmd_wdata[31:16] != 16'h0000));

  // command answer one cycle after the request
  // rdata forced to zero outside reads so the bus idles quietly
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_rdata <= 32'h0000_0000;
      cmd_ack   <= 1'b0;
      cmd_err   <= 1'b0;
    end
    else
    begin
      cmd_ack   <= cmd_wr || cmd_rd;
      cmd_err   <= (cmd_rd && !rd_hit) || (cmd_wr && wr_bad);
      cmd_rdata <= cmd_rd ? rd_val : 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

// [design/rls_pkg.sv]
`default_nettype none

package rls_pkg;

  // register indices on the command port
  localparam logic [4:0] REG_TX_BYTE      = 5'h00;
  localparam logic [4:0] REG_RX_LEVEL     = 5'h01;
  localparam logic [4:0] REG_BAD_PKT      = 5'h02;
  localparam logic [4:0] REG_GOOD_PKT     = 5'h03;
  localparam logic [4:0] REG_ACK_TMO      = 5'h04;
  localparam logic [4:0] REG_SEND_FAIL    = 5'h05;
  localparam logic [4:0] REG_ACKED_UNI    = 5'h06;
  localparam logic [4:0] REG_UNI_HOP_TMO  = 5'h07;
  localparam logic [4:0] REG_BC_HOP_TMO   = 5'h08;
  localparam logic [4:0] REG_ROLE         = 5'h09;
  localparam logic [4:0] REG_FLOOD_HOPS   = 5'h0A;
  localparam logic [4:0] REG_MAX_HOPS     = 5'h0B;
  localparam logic [4:0] REG_RELAY_SPAN   = 5'h0C;
  localparam logic [4:0] REG_RESEND_CAP   = 5'h0D;
  localparam logic [4:0] REG_BACKOFF_MAX  = 5'h0E;
  localparam logic [4:0] REG_OWN_TOP      = 5'h0F;
  localparam logic [4:0] REG_OWN_BOT      = 5'h10;
  localparam logic [4:0] REG_TGT_TOP      = 5'h11;
  localparam logic [4:0] REG_TGT_BOT      = 5'h12;

  // reset values and the tally ceiling
  localparam logic [15:0] TALLY_RST       = 16'h0000;
  localparam logic [15:0] TALLY_MAX       = 16'hFFFF;
  localparam logic [7:0]  RX_LEVEL_RST    = 8'h00;
  localparam logic [15:0] UNI_HOP_TMO_RST = 16'h00CF;
  localparam logic [15:0] BC_HOP_TMO_RST  = 16'h01BE;
  localparam logic [7:0]  ROLE_RST        = 8'h00;
  localparam logic [7:0]  FLOOD_HOPS_RST  = 8'h00;
  localparam logic [7:0]  MAX_HOPS_RST    = 8'h07;
  localparam logic [7:0]  RELAY_SPAN_RST  = 8'h03;
  localparam logic [7:0]  RESEND_CAP_RST  = 8'h01;
  localparam logic [7:0]  BACKOFF_MAX_RST = 8'h00;
  localparam logic [31:0] TGT_TOP_RST     = 32'h0000_0000;
  localparam logic [31:0] TGT_BOT_RST     = 32'h0000_FFFF;
  localparam logic [15:0] LFSR_SEED       = 16'hACE1;
  localparam logic        NET_ACK_EN_RST  = 1'b1;
  localparam logic [3:0]  NET_TRIES_RST   = 4'h2;

  // legal ranges
  localparam logic [7:0]  ROLE_MAX        = 8'h06;
  localparam logic [7:0]  HOPS_LIMIT      = 8'h20;
  localparam logic [7:0]  HOPS_MIN        = 8'h01;
  localparam logic [7:0]  RELAY_SPAN_MIN  = 8'h01;
  localparam logic [7:0]  RELAY_SPAN_MAX  = 8'h05;
  localparam logic [7:0]  RESEND_CAP_MAX  = 8'h07;

  // role field bit positions
  localparam int ROLE_HOLD_BIT  = 0;
  localparam int ROLE_NOROUTE_BIT = 1;
  localparam int ROLE_POLL_BIT  = 2;

  // backoff slot timing
  localparam int SYS_CLK_HZ      = 20_000_000;
  localparam int SLOT_MS         = 38;
  localparam int SLOT_CYCLES     = SYS_CLK_HZ / 1000 * SLOT_MS;

  // factory address, arbitrary neutral value
  localparam logic [63:0] OWN_ADDR_DEF = 64'h0000_0000_0000_0001;

endpackage

`default_nettype wire

// [testbench/rls_bank_sva.sv]
`timescale 1ns/1ps
`default_nettype none

module rls_bank_sva (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        cmd_wr,
  input wire logic        cmd_rd,
  input wire logic [31:0] cmd_rdata,
  input wire logic        cmd_ack,
  input wire logic        cmd_err,
  input wire logic        relay_wait_req,
  input wire logic        resend_wait_req,
  input wire logic        relay_wait_busy,
  input wire logic        resend_wait_busy,
  input wire logic [7:0]  role_bits,
  input wire logic [7:0]  flood_hops_eff,
  input wire logic [7:0]  max_hops,
  input wire logic        net_ack_en,
  input wire logic [3:0]  net_send_tries
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_ack_follows_req:
    assert property ((cmd_wr || cmd_rd) |=> cmd_ack) else $error("no ack after request");
  a_no_stray_ack:
    assert property (!(cmd_wr || cmd_rd) |=> !cmd_ack) else $error("ack without request");
  a_err_with_ack:
    assert property (cmd_err |-> cmd_ack) else $error("err without ack");
  a_rdata_quiet:
    assert property (!cmd_ack |-> cmd_rdata == 32'h0000_0000) else $error("rdata not idle");
  a_role_legal:
    assert property (role_bits <= 8'h06 && !(role_bits[0] && role_bits[2])) else $error("illegal role");
  a_flood_clipped:
    assert property (flood_hops_eff <= max_hops) else $error("flood hops above max");
  a_hops_range:
    assert property (max_hops >= 8'h01 && max_hops <= 8'h20) else $error("max hops out of range");
  a_tries_pair:
    assert property (net_ack_en == (net_send_tries != 4'h1) && net_send_tries inside {[1:8]})
    else $error("tries and ack enable disagree");
  a_relay_cause:
    assert property ($rose(relay_wait_busy) |-> $past(relay_wait_req)) else $error("relay wait uncaused");
  a_resend_cause:
    assert property ($rose(resend_wait_busy) |-> $past(resend_wait_req)) else $error("resend wait uncaused");
endmodule

bind rls_bank rls_bank_sva u_rls_bank_sva (.*);

`default_nettype wire

// [testbench/rls_host.sv]
`timescale 1ns/1ps
`default_nettype none

// host controller: one command per call, an idle cycle between calls
module rls_host (
  input  wire logic        clk_sys,
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic [4:0]       cmd_idx,
  output logic [31:0]      cmd_wdata,
  input  wire logic [31:0] cmd_rdata,
  input  wire logic        cmd_ack,
  input  wire logic        cmd_err
);
  initial
  begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_idx = 5'h00;
    cmd_wdata = 32'h0000_0000;
  end

  // request stands for one taking edge; answer stands the cycle after
  task automatic xfer(input logic w, input logic [4:0] i, input logic [31:0] d,
                      output logic [31:0] q, output logic a, output logic r);
    @(posedge clk_sys);
    #1;
    cmd_wr = w;
    cmd_rd = !w;
    cmd_idx = i;
    cmd_wdata = d;
    @(posedge clk_sys);
    #1;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    q = cmd_rdata;
    a = cmd_ack;
    r = cmd_err;
  endtask
endmodule

`default_nettype wire

// [testbench/radio_link_stats_params_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module radio_link_stats_params_tb;
  import rls_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_wr, cmd_rd, cmd_ack, cmd_err;
  logic [4:0]  cmd_idx;
  logic [31:0] cmd_wdata, cmd_rdata;
  logic [9:0]  ev = 10'h000;          // event lines, driven one pulse at a time
  logic        ev_rx_is_ack = 1'b0;
  logic [7:0]  rx_level_in = 8'h00;
  logic [15:0] uni_hop_tmo_in = 16'h0100;
  logic [15:0] bc_hop_tmo_in = 16'h0200;
  logic        relay_wait_busy, resend_wait_busy, net_ack_en;
  logic [7:0]  role_bits, flood_hops_eff, max_hops;
  logic [3:0]  net_send_tries;
  logic [63:0] target_address;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  wire ev_tx_byte       = ev[0];
  wire ev_rx_bad        = ev[1];
  wire ev_rx_good       = ev[2];
  wire ev_ack_timeout   = ev[3];
  wire ev_send_fail     = ev[4];
  wire ev_acked_unicast = ev[5];
  wire ev_rx_data       = ev[6];
  wire hop_tmo_load     = ev[7];
  wire relay_wait_req   = ev[8];
  wire resend_wait_req  = ev[9];
  // tally index matching each of the first six event lines
  logic [4:0]  tidx [6] = '{REG_TX_BYTE, REG_BAD_PKT, REG_GOOD_PKT, REG_ACK_TMO, REG_SEND_FAIL, REG_ACKED_UNI};

  rls_bank #(.SLOT_LEN(4)) u_rls_bank (.*);
  rls_host u_rls_host (.*);

  always #25 clk_sys = ~clk_sys;

  // hang guard, far above the roughly 1250 cycles the tests take
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [4:0] i, input logic [31:0] d, input logic e);
    logic [31:0] q;
    logic        a, r;
    u_rls_host.xfer(1'b1, i, d, q, a, r);
    chk("wr ack", 64'h1, a);
    chk("wr err", e, r);
  endtask

  task automatic rd(input logic [4:0] i, input logic [31:0] x);
    logic [31:0] q;
    logic        a, r;
    u_rls_host.xfer(1'b0, i, 32'h0000_0000, q, a, r);
    chk("rd ack", 64'h1, a);
    chk("rdata", x, q);
  endtask

  // n single-cycle pulses on event line k
  task automatic pulse(input int k, input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      #1 ev[k] = 1'b1;
      @(posedge clk_sys);
      #1 ev[k] = 1'b0;
    end
  endtask

  // let the registered configuration outputs catch up
  task automatic settle();
    @(posedge clk_sys);
    #1;
  endtask

  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    for (int k = 0; k < 6; k++) rd(tidx[k], 32'h0000_0000);
    rd(REG_RX_LEVEL, 32'h0000_0000);
    rd(REG_UNI_HOP_TMO, 32'h0000_00cf);
    rd(REG_BC_HOP_TMO, 32'h0000_01be);
    rd(REG_ROLE, 32'h0000_0000);
    rd(REG_FLOOD_HOPS, 32'h0000_0000);
    rd(REG_MAX_HOPS, 32'h0000_0007);
    rd(REG_RELAY_SPAN, 32'h0000_0003);
    rd(REG_RESEND_CAP, 32'h0000_0001);
    rd(REG_BACKOFF_MAX, 32'h0000_0000);
    rd(REG_OWN_TOP, OWN_ADDR_DEF[63:32]);
    chk("target", 64'h0000_0000_0000_ffff, target_address);
    $display("test reset values done");
    // byte tally wraps, the rest stop at the top
    for (int k = 0; k < 6; k++)
    begin
      wr(tidx[k], 32'h0000_fffe, 1'b0);
      pulse(k, 2);
      rd(tidx[k], (k == 0) ? 32'h0000_0000 : 32'h0000_ffff);
    end
    wr(REG_GOOD_PKT, 32'h0000_0010, 1'b0);
    ev_rx_is_ack = 1'b1;
    pulse(2, 1);
    ev_rx_is_ack = 1'b0;
    pulse(2, 1);
    rd(REG_GOOD_PKT, 32'h0000_0011);
    wr(REG_BAD_PKT, 32'h0001_0005, 1'b1);
    rd(REG_BAD_PKT, 32'h0000_0005);
    $display("test tallies done");
    rx_level_in = 8'h60;
    pulse(6, 1);
    rx_level_in = 8'h11;
    rd(REG_RX_LEVEL, 32'h0000_0060);
    wr(REG_RX_LEVEL, 32'h0000_0001, 1'b1);
    wr(REG_UNI_HOP_TMO, 32'h0000_0005, 1'b1);
    pulse(7, 1);
    rd(REG_UNI_HOP_TMO, 32'h0000_0100);
    rd(REG_BC_HOP_TMO, 32'h0000_0200);
    wr(REG_OWN_BOT, 32'h0000_0000, 1'b1);
    rd(REG_OWN_BOT, OWN_ADDR_DEF[31:0]);
    wr(5'h1f, 32'h0000_0000, 1'b1);
    $display("test read-only done");
    wr(REG_ROLE, 32'h0000_0005, 1'b1);
    wr(REG_ROLE, 32'h0000_0007, 1'b1);
    wr(REG_ROLE, 32'h0000_0006, 1'b0);
    wr(REG_MAX_HOPS, 32'h0000_0000, 1'b1);
    wr(REG_MAX_HOPS, 32'h0000_0021, 1'b1);
    wr(REG_MAX_HOPS, 32'h0000_0004, 1'b0);
    wr(REG_FLOOD_HOPS, 32'h0000_0021, 1'b1);
    wr(REG_FLOOD_HOPS, 32'h0000_0020, 1'b0);
    wr(REG_RESEND_CAP, 32'h0000_0000, 1'b0);
    settle();
    chk("role", 8'h06, role_bits);
    chk("max hops", 8'h04, max_hops);
    chk("flood", 8'h04, flood_hops_eff);
    chk("ack_en", 1'b0, net_ack_en);
    chk("tries", 4'h1, net_send_tries);
    wr(REG_RESEND_CAP, 32'h0000_0008, 1'b1);
    wr(REG_RESEND_CAP, 32'h0000_0007, 1'b0);
    settle();
    chk("tries", 4'h8, net_send_tries);
    $display("test config done");
    wr(REG_RELAY_SPAN, 32'h0000_0006, 1'b1);
    wr(REG_RELAY_SPAN, 32'h0000_0005, 1'b0);
    pulse(8, 1);
    chk("relay busy", 1'b1, relay_wait_busy);
    repeat (30) settle();
    chk("relay busy", 1'b0, relay_wait_busy);
    pulse(9, 1);
    repeat (4) settle();
    chk("resend busy", 1'b0, resend_wait_busy);
    // a setting of one allows only a zero-slot pick
    wr(REG_BACKOFF_MAX, 32'h0000_0001, 1'b0);
    pulse(9, 1);
    chk("resend busy", 1'b0, resend_wait_busy);
    wr(REG_BACKOFF_MAX, 32'h0000_00ff, 1'b0);
    pulse(9, 1);
    repeat (1030) settle();
    chk("resend busy", 1'b0, resend_wait_busy);
    $display("test backoff done");
    wr(REG_TGT_TOP, 32'h1234_5678, 1'b0);
    wr(REG_TGT_BOT, 32'h9abc_def0, 1'b0);
    settle();
    chk("target", 64'h1234_5678_9abc_def0, target_address);
    rst_n = 1'b0;
    settle();
    rst_n = 1'b1;
    rd(REG_GOOD_PKT, 32'h0000_0000);
    rd(REG_RX_LEVEL, 32'h0000_0000);
    rd(REG_TGT_BOT, 32'h0000_ffff);
    chk("max hops", 8'h07, max_hops);
    $display("test second reset done");
    complete_run();
  end
endmodule

`default_nettype wire
